// ===== prs_defs.svh
// Constants for the PLL reference select and state control block.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef PRS_DEFS_SVH
`define PRS_DEFS_SVH

// ----------------------------------------
// Reference select field encodings
// ----------------------------------------
`define PRS_REFERENCE_SELECT_FIELD_AUTO     2'h0
`define PRS_REFERENCE_SELECT_FIELD_MAN0     2'h1
`define PRS_REFERENCE_SELECT_FIELD_MAN1     2'h2
`define PRS_REFERENCE_SELECT_FIELD_PIN      2'h3

// ----------------------------------------
// State force field and bypass sources
// ----------------------------------------
`define PRS_FORCE_NONE      2'h0
`define PRS_FORCE_FREERUN   2'h1
`define PRS_BYP_NONE        2'h0
`define PRS_BYP_XTAL        2'h1
`define PRS_BYP_REF0        2'h2
`define PRS_BYP_REF1        2'h3
`define PRS_BYPASS_MAX_MHZ  250

// ----------------------------------------
// Validation count and reset values
// ----------------------------------------
`define PRS_VALID_EDGES     4'h8
`define PRS_SEL_RST         1'h0

`endif

// ===== prs_los_validator.sv
// Per-input loss-of-signal alarm with edge-count revalidation.
// Assumes the loss flag comes from the monitor on the core clock.
`timescale 1ns/1ps
`include "prs_defs.svh"
module prs_los_validator (
  // Clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // Reference activity and monitor flag
  input  wire logic ref_pin,
  input  wire logic los_det,
  // Alarm out
  output logic      alarm
);
  import prs_pkg::*;

  logic       sync1_q;
  logic       sync2_q;
  logic       prev_q;
  logic       rise;
  logic [3:0] cnt_q;
  logic       alarm_q;

  // ----------------------------------------
  // Pin synchroniser and edge detect
  // ----------------------------------------
  // Limitation: only edges slow enough for the core clock are counted
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_q <= 1'h0;
      sync2_q <= 1'h0;
      prev_q  <= 1'h0;
    end else begin
      sync1_q <= ref_pin;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
    end
  end

  assign rise = sync2_q & ~prev_q;

  // ----------------------------------------
  // Alarm and revalidation counter
  // ----------------------------------------
  // Input starts failed so it must prove itself after reset
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      alarm_q <= 1'h1;
      cnt_q   <= 4'h0;
    end else if (los_det) begin
      alarm_q <= 1'h1;
      cnt_q   <= 4'h0;
    end else if (alarm_q && rise) begin
      if (cnt_q == `PRS_VALID_EDGES - 4'h1) begin
        alarm_q <= 1'h0;
        cnt_q   <= 4'h0;
      end else begin
        cnt_q <= cnt_q + 4'h1;
      end
    end
  end

  assign alarm = alarm_q;

  AST_LOS_SETS: assert property (@(posedge clk) disable iff (!rst_n)
    los_det |=> alarm_q && cnt_q == 4'h0) else $error("loss flag did not raise alarm");
  AST_EIGHTH_EDGE: assert property (@(posedge clk) disable iff (!rst_n)
    (alarm_q && !los_det && rise && cnt_q == 4'h7) |=> !alarm_q) else $error("alarm kept after eight edges");
  AST_NOT_EARLY: assert property (@(posedge clk) disable iff (!rst_n)
    (alarm_q && cnt_q < 4'h7) |=> alarm_q) else $error("alarm cleared before eight edges");

endmodule // prs_los_validator

// ===== prs_pkg.sv
// Types shared by the reference select block.
// Assumes prs_defs.svh is available on the include path.
package prs_pkg;

  `include "prs_defs.svh"

  typedef enum logic [1:0] {
    PRS_FREERUN,
    PRS_LOCK,
    PRS_HOLDOVER
  } prs_state_t;

endpackage

// ===== prs_ref_model.sv
// Behavioural model of the two upstream reference clocks.
// Assumes the bench enables each source; a stopped input sits at its pulldown level.
`timescale 1ns/1ps
module prs_ref_model (
  // Enables and pace
  input  wire logic [1:0] run,
  input  wire logic [1:0] slow,
  // Reference outputs
  output logic            ref_zero,
  output logic            ref_one
);
  // ----------------------------------------
  // Sources
  // ----------------------------------------
  // Half periods are whole core clock periods, so only the 7 ns idle step sets the phase
  always begin
    if (run[0]) begin
      #(slow[0] ? 45 : 20);
      ref_zero = ~ref_zero;
    end else begin
      ref_zero = 1'b0;
      #7;
    end
  end

  always begin
    if (run[1]) begin
      #(slow[1] ? 45 : 20);
      ref_one = ~ref_one;
    end else begin
      ref_one = 1'b0;
      #7;
    end
  end
endmodule // prs_ref_model

// ===== prs_ref_select.sv
// PLL state machine, reference selection, bypass routing and alarms.
// Assumes per-input loss flags from the monitor on CORE_CLK and
// reference activity and the select pin arriving asynchronously.
`timescale 1ns/1ps
`include "prs_defs.svh"
module prs_ref_select (
  // Clock and reset
  input  wire logic               CORE_CLK,
  input  wire logic               RST_N,
  // Reference inputs and monitor flags
  input  wire logic               REFERENCE_INPUT_ZERO,
  input  wire logic               REFERENCE_INPUT_ONE,
  input  wire logic [1:0]         LOS_DETECT,
  // Selection configuration
  input  wire logic [1:0]         REFERENCE_SELECT_FIELD,
  input  wire logic               PRIORITY_ONE_HIGH,
  input  wire logic               REVERTIVE_EN,
  input  wire logic               SYNTHESIZER_ENABLE_BIT,
  input  wire logic [1:0]         STATE_FORCE,
  // Crystal and bypass configuration
  input  wire logic               XTAL_DOUBLER_EN,
  input  wire logic [1:0]         BYPASS_SRC_Q2,
  input  wire logic [1:0]         BYPASS_SRC_Q3,
  // Alarm control
  input  wire logic               HOLD_ALARM_CLR,
  input  wire logic               INT_ENABLE,
  // Clock select pin, two-way
  input  wire logic               GPIO2_I,
  output logic                    GPIO2_O,
  output logic                    GPIO2_OE,
  // Lock status pin
  output logic                    GPIO3_O,
  // Interrupt, open drain
  output logic                    INTERRUPT_OUT_N_O,
  output logic                    INTERRUPT_OUT_N_OE,
  // State and status
  output prs_pkg::prs_state_t     PLL_STATE,
  output logic                    SELECTED_REF,
  output logic                    LOCK_STATUS,
  output logic                    HOLDOVER_STATUS,
  output logic                    HOLD_ALARM,
  output logic [1:0]              LOS_ALARM,
  // PLL path controls
  output logic                    XTAL_DOUBLE_ON,
  output logic [1:0]              Q2_BYPASS_ROUTE,
  output logic [1:0]              Q3_BYPASS_ROUTE
);
  import prs_pkg::*;

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [1:0] alarm;
  logic [1:0] valid;
  logic       pin_clock_choice_s1_q;
  logic       pin_clock_choice_s2_q;
  logic       force_fr;
  logic       auto_mode;
  logic       hi_ref;
  logic       chosen;
  prs_state_t state_q;
  prs_state_t state_d;
  logic       sel_q;
  logic       sel_d;
  logic       hold_alarm_q;
  logic       int_oe_q;
  logic       int_o_q;
  logic       gpio2_o_q;
  logic       gpio2_oe_q;
  logic       gpio3_o_q;
  logic       lock_q;
  logic       hold_q;
  logic [1:0] los_q;
  logic       dbl_q;
  logic [1:0] byp2_q;
  logic [1:0] byp3_q;

  // ----------------------------------------
  // Input validation
  // ----------------------------------------
  prs_los_validator u_val0 (
    .clk     (CORE_CLK),
    .rst_n   (RST_N),
    .ref_pin (REFERENCE_INPUT_ZERO),
    .los_det (LOS_DETECT[0]),
    .alarm   (alarm[0])
  );

  prs_los_validator u_val1 (
    .clk     (CORE_CLK),
    .rst_n   (RST_N),
    .ref_pin (REFERENCE_INPUT_ONE),
    .los_det (LOS_DETECT[1]),
    .alarm   (alarm[1])
  );

  assign valid = ~alarm;

  // ----------------------------------------
  // Clock select pin synchroniser
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      pin_clock_choice_s1_q <= 1'h0;
      pin_clock_choice_s2_q <= 1'h0;
    end else begin
      pin_clock_choice_s1_q <= GPIO2_I;
      pin_clock_choice_s2_q <= pin_clock_choice_s1_q;
    end
  end

  // ----------------------------------------
  // Mode decode
  // ----------------------------------------
  assign force_fr  = SYNTHESIZER_ENABLE_BIT && (STATE_FORCE == `PRS_FORCE_FREERUN);
  assign auto_mode = (REFERENCE_SELECT_FIELD == `PRS_REFERENCE_SELECT_FIELD_AUTO);
  assign hi_ref    = PRIORITY_ONE_HIGH;

  // Manual choice: field names the input, or the pin does
  always_comb begin
    case (REFERENCE_SELECT_FIELD)
      `PRS_REFERENCE_SELECT_FIELD_MAN0: chosen = 1'h0;
      `PRS_REFERENCE_SELECT_FIELD_MAN1: chosen = 1'h1;
      `PRS_REFERENCE_SELECT_FIELD_PIN:  chosen = pin_clock_choice_s2_q;
      default:          chosen = sel_q;
    endcase
  end

  // ----------------------------------------
  // Selection and state decision
  // ----------------------------------------
  always_comb begin
    sel_d   = sel_q;
    state_d = state_q;
    if (force_fr) begin
      state_d = PRS_FREERUN;
    end else if (auto_mode) begin
      if (state_q == PRS_LOCK && valid[sel_q]) begin
        // Current input still good
        if (REVERTIVE_EN && valid[hi_ref]) begin
          sel_d = hi_ref;
        end else begin
          sel_d = sel_q;
        end
        state_d = PRS_LOCK;
      end else if (valid[hi_ref]) begin
        sel_d   = hi_ref;
        state_d = PRS_LOCK;
      end else if (valid[~hi_ref]) begin
        sel_d   = ~hi_ref;
        state_d = PRS_LOCK;
      end else if (state_q == PRS_FREERUN) begin
        state_d = PRS_FREERUN;
      end else begin
        state_d = PRS_HOLDOVER;
      end
    end else begin
      // Never falls over to the other input in manual mode
      sel_d = chosen;
      if (valid[chosen]) begin
        state_d = PRS_LOCK;
      end else if (state_q == PRS_FREERUN) begin
        state_d = PRS_FREERUN;
      end else begin
        state_d = PRS_HOLDOVER;
      end
    end
  end

  // ----------------------------------------
  // State and selection registers
  // ----------------------------------------
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_q <= PRS_FREERUN;
      sel_q   <= `PRS_SEL_RST;
    end else begin
      state_q <= state_d;
      sel_q   <= sel_d;
    end
  end

  // ----------------------------------------
  // Status and alarms
  // ----------------------------------------
  // Set wins over clear so a holdover entry is never missed
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      hold_alarm_q <= 1'h0;
    end else if (state_d == PRS_HOLDOVER && state_q != PRS_HOLDOVER) begin
      hold_alarm_q <= 1'h1;
    end else if (HOLD_ALARM_CLR) begin
      hold_alarm_q <= 1'h0;
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      lock_q    <= 1'h0;
      hold_q    <= 1'h0;
      gpio3_o_q <= 1'h0;
      los_q     <= 2'h3;
    end else begin
      lock_q    <= (state_d == PRS_LOCK);
      hold_q    <= (state_d == PRS_HOLDOVER);
      gpio3_o_q <= (state_d == PRS_LOCK);
      los_q     <= alarm;
    end
  end

  // ----------------------------------------
  // Pins: select pin direction and interrupt
  // ----------------------------------------
  // The pin is released only in reset and while it serves as the select input
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      gpio2_oe_q <= 1'h0;
      gpio2_o_q  <= 1'h0;
      int_o_q    <= 1'h0;
      int_oe_q   <= 1'h0;
    end else begin
      gpio2_oe_q <= (REFERENCE_SELECT_FIELD != `PRS_REFERENCE_SELECT_FIELD_PIN);
      gpio2_o_q  <= hold_alarm_q;
      int_o_q    <= 1'h0;
      int_oe_q   <= INT_ENABLE && (hold_alarm_q || (|alarm));
    end
  end

  // ----------------------------------------
  // Crystal doubler and bypass routing
  // ----------------------------------------
  // Frequency cap cannot be measured here; software must respect it
  function automatic logic [1:0] byp_route(input logic [1:0] src, input logic [1:0] v);
    logic [1:0] r;
    r = src;
    if ((src == `PRS_BYP_REF0 && !v[0]) || (src == `PRS_BYP_REF1 && !v[1])) begin
      r = `PRS_BYP_NONE;
    end
    return r;
  endfunction

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      dbl_q  <= 1'h0;
      byp2_q <= `PRS_BYP_NONE;
      byp3_q <= `PRS_BYP_NONE;
    end else begin
      dbl_q  <= XTAL_DOUBLER_EN;
      byp2_q <= byp_route(BYPASS_SRC_Q2, valid);
      byp3_q <= byp_route(BYPASS_SRC_Q3, valid);
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign PLL_STATE          = state_q;
  assign SELECTED_REF       = sel_q;
  assign LOCK_STATUS        = lock_q;
  assign HOLDOVER_STATUS    = hold_q;
  assign HOLD_ALARM         = hold_alarm_q;
  assign LOS_ALARM          = los_q;
  assign GPIO2_O            = gpio2_o_q;
  assign GPIO2_OE           = gpio2_oe_q;
  assign GPIO3_O            = gpio3_o_q;
  assign INTERRUPT_OUT_N_O  = int_o_q;
  assign INTERRUPT_OUT_N_OE = int_oe_q;
  assign XTAL_DOUBLE_ON     = dbl_q;
  assign Q2_BYPASS_ROUTE    = byp2_q;
  assign Q3_BYPASS_ROUTE    = byp3_q;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  AST_THREE_STATES: assert property (
    state_q inside {PRS_FREERUN, PRS_LOCK, PRS_HOLDOVER}) else $error("illegal PLL state");
  AST_NO_REF_FREERUN: assert property (
    (state_q == PRS_FREERUN && valid == 2'h0) |=> state_q == PRS_FREERUN) else $error("left free-run without input");
  AST_AUTO_LOCK: assert property (
    (!force_fr && auto_mode && valid != 2'h0) |=> state_q == PRS_LOCK) else $error("no lock with valid input");
  AST_AUTO_HOLDOVER: assert property (
    (!force_fr && auto_mode && state_q == PRS_LOCK && valid == 2'h0) |=> state_q == PRS_HOLDOVER)
    else $error("no holdover after total loss");
  AST_AUTO_SWITCH: assert property (
    (!force_fr && auto_mode && state_q == PRS_LOCK && !valid[sel_q] && valid[~sel_q])
    |=> (sel_q != $past(sel_q)) && state_q == PRS_LOCK) else $error("failed to switch to other input");
  AST_REVERT: assert property (
    (!force_fr && auto_mode && REVERTIVE_EN && valid[hi_ref]) |=> sel_q == $past(hi_ref))
    else $error("did not revert to preferred input");
  AST_NON_REVERT: assert property (
    (!force_fr && auto_mode && !REVERTIVE_EN && state_q == PRS_LOCK && valid[sel_q]) |=> $stable(sel_q))
    else $error("non-revertive selection moved");
  AST_MANUAL_HOLD: assert property (
    (!force_fr && !auto_mode && state_q == PRS_LOCK && !valid[chosen])
    |=> state_q == PRS_HOLDOVER && sel_q == $past(chosen)) else $error("manual loss did not hold");
  AST_HOLD_ALARM_SET: assert property (
    (state_q == PRS_HOLDOVER && $past(state_q) != PRS_HOLDOVER) |-> hold_alarm_q && hold_q)
    else $error("holdover entry without alarm");
  AST_SYNTH_FREERUN: assert property (
    force_fr |=> state_q == PRS_FREERUN && !lock_q) else $error("forced free-run ignored");
  AST_STATUS_PIN: assert property (
    ##1 (lock_q == (state_q == PRS_LOCK)) && (gpio3_o_q == lock_q)) else $error("lock status mismatch");

  // Status, pin and routing checks
  AST_HOLD_STATUS: assert property (
    hold_q == (state_q == PRS_HOLDOVER) && gpio3_o_q == (state_q == PRS_LOCK))
    else $error("holdover status mismatch");
  AST_HOLD_STICKY: assert property (
    (hold_alarm_q && !HOLD_ALARM_CLR) |=> hold_alarm_q)
    else $error("holdover alarm dropped without clear");
  AST_ALARM_PIN: assert property (
    1'h1 |=> gpio2_o_q == $past(hold_alarm_q))
    else $error("alarm pin does not follow holdover alarm");
  AST_INT_PULL: assert property (
    (INT_ENABLE && hold_alarm_q) |=> int_oe_q && !int_o_q)
    else $error("interrupt not pulled low on holdover alarm");
  AST_INT_MASK: assert property (
    !INT_ENABLE |=> !int_oe_q)
    else $error("masked interrupt pulled low");
  AST_MANUAL_FOLLOW: assert property (
    (!force_fr && !auto_mode) |=> sel_q == $past(chosen))
    else $error("manual selection left the chosen input");
  AST_PIN_RELEASE: assert property (
    (REFERENCE_SELECT_FIELD == `PRS_REFERENCE_SELECT_FIELD_PIN) |=> !gpio2_oe_q)
    else $error("select pin driven in pin mode");
  AST_PIN_CHOICE: assert property (
    (!force_fr && REFERENCE_SELECT_FIELD == `PRS_REFERENCE_SELECT_FIELD_PIN) |=> sel_q == $past(pin_clock_choice_s2_q))
    else $error("pin choice not followed");
  AST_BYPASS_GUARD: assert property (
    (BYPASS_SRC_Q2 == `PRS_BYP_REF1 && !valid[1]) |=> byp2_q == `PRS_BYP_NONE)
    else $error("failed input routed to bypass");
  AST_DOUBLER: assert property (
    1'h1 |=> dbl_q == $past(XTAL_DOUBLER_EN))
    else $error("doubler control not registered");
  AST_LOS_STATUS: assert property (
    1'h1 |=> los_q == $past(alarm))
    else $error("input alarm status mismatch");

  COV_LOCK: cover property (state_q == PRS_FREERUN ##1 state_q == PRS_LOCK);
  COV_HOLD: cover property (state_q == PRS_LOCK ##1 state_q == PRS_HOLDOVER);
  COV_SWITCH: cover property (state_q == PRS_LOCK && $changed(sel_q));
  COV_RELOCK: cover property (state_q == PRS_HOLDOVER ##1 state_q == PRS_LOCK);
  COV_FORCE: cover property (state_q == PRS_LOCK ##1 state_q == PRS_FREERUN);

endmodule // prs_ref_select

// ===== test_pll_reference_select_fsm.sv
// Self-checking bench for the PLL state and reference select block.
// Assumes prs_pkg is compiled first and prs_ref_model supplies the references.
`timescale 1ns/1ps
`include "prs_defs.svh"
module test_pll_reference_select_fsm;
  import prs_pkg::*;
  typedef struct {int idx; logic [7:0] v;} prs_note_t;

  // ----------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------
  logic       CORE_CLK = 1'b0;
  logic       RST_N    = 1'b0;
  logic [1:0] run = 2'h0, slow = 2'h2, los = 2'h0, sel = 2'h0, bq2 = 2'h0, bq3 = 2'h0, frc = 2'h0;
  logic       pri = 1'b0, rev = 1'b0, syn = 1'b0, dbl = 1'b0, hclr = 1'b0, inten = 1'b1, pin_drv = 1'b0;
  logic       ref0, ref1, g2o, g2oe, g3o, into, intoe, selref, lk, ho, ha, xd;
  logic [1:0] losa, r2, r3;
  prs_state_t st;
  int         fail_count = 0;
  int         n_tests = 0;
  prs_note_t  q[$];
  prs_note_t  cur;
  event       chk_ev;
  string      nm [13] = '{"state", "sel", "lock", "hold", "halarm", "los", "gpio3", "g2oe", "int_n", "q2",
                          "q3", "dbl", "g2o"};
  // Bench drive on the select pin and a pullup on the interrupt line
  wire        gpio2_w = g2oe ? g2o : pin_drv;
  wire        int_n_w = intoe ? into : 1'b1;

  always #2.5 CORE_CLK = ~CORE_CLK;

  prs_ref_model model_u (.run(run), .slow(slow), .ref_zero(ref0), .ref_one(ref1));

  prs_ref_select dut_u (
    .CORE_CLK(CORE_CLK), .RST_N(RST_N), .REFERENCE_INPUT_ZERO(ref0), .REFERENCE_INPUT_ONE(ref1),
    .LOS_DETECT(los), .REFERENCE_SELECT_FIELD(sel), .PRIORITY_ONE_HIGH(pri), .REVERTIVE_EN(rev),
    .SYNTHESIZER_ENABLE_BIT(syn), .STATE_FORCE(frc), .XTAL_DOUBLER_EN(dbl), .BYPASS_SRC_Q2(bq2),
    .BYPASS_SRC_Q3(bq3), .HOLD_ALARM_CLR(hclr), .INT_ENABLE(inten), .GPIO2_I(gpio2_w), .GPIO2_O(g2o),
    .GPIO2_OE(g2oe), .GPIO3_O(g3o), .INTERRUPT_OUT_N_O(into), .INTERRUPT_OUT_N_OE(intoe), .PLL_STATE(st),
    .SELECTED_REF(selref), .LOCK_STATUS(lk), .HOLDOVER_STATUS(ho), .HOLD_ALARM(ha), .LOS_ALARM(losa),
    .XTAL_DOUBLE_ON(xd), .Q2_BYPASS_ROUTE(r2), .Q3_BYPASS_ROUTE(r3)
  );

  // ----------------------------------------
  // Checking
  // ----------------------------------------
  function automatic logic [7:0] obs(int i);
    case (i)
      0: return 8'(st);
      1: return {7'h0, selref};
      2: return {7'h0, lk};
      3: return {7'h0, ho};
      4: return {7'h0, ha};
      5: return {6'h0, losa};
      6: return {7'h0, g3o};
      7: return {7'h0, g2oe};
      8: return {7'h0, int_n_w};
      9: return {6'h0, r2};
      10: return {6'h0, r3};
      11: return {7'h0, xd};
      default: return {7'h0, g2o};
    endcase
  endfunction

  task automatic check(string what, logic [7:0] seen, logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  task automatic expect_v(int i, logic [7:0] v);
    @(negedge CORE_CLK);
    q.push_back('{i, v});
    -> chk_ev;
  endtask

  // Bounded wait for a level, then the note goes on the queue
  task automatic wait_for(int i, logic [7:0] v);
    int k;
    k = 0;
    while (obs(i) !== v && k < 400) begin
      @(negedge CORE_CLK);
      k++;
    end
    expect_v(i, v);
  endtask

  always @(chk_ev) begin
    while (q.size() > 0) begin
      cur = q.pop_front();
      check(nm[cur.idx], obs(cur.idx), cur.v);
    end
  end

  task automatic fail_in(int i);
    @(posedge CORE_CLK);
    run[i] <= 1'b0;
    los[i] <= 1'b1;
    @(posedge CORE_CLK);
    los[i] <= 1'b0;
  endtask

  task automatic test_done(string s);
    $display("Test %s finished, %0d checks so far", s, n_tests);
  endtask

  task automatic complete_run();
    $display("Checks made %0d, mismatches %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge CORE_CLK);
    $display("Watchdog expired");
    fail_count++;
    complete_run();
  end

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(10529));
    repeat (9) @(posedge CORE_CLK);
    expect_v(0, 8'(PRS_FREERUN));
    expect_v(5, 8'h3);
    expect_v(7, 8'h0);
    @(posedge CORE_CLK);
    RST_N <= 1'b1;
    repeat (50) @(posedge CORE_CLK);
    expect_v(0, 8'(PRS_FREERUN));
    expect_v(2, 8'h0);
    expect_v(7, 8'h1);
    test_done("reset");
    // Both references start, auto non-revertive, input zero preferred
    @(posedge CORE_CLK);
    run <= 2'h3;
    wait_for(0, 8'(PRS_LOCK));
    expect_v(1, 8'h0);
    expect_v(2, 8'h1);
    expect_v(6, 8'h1);
    wait_for(5, 8'h0);
    @(posedge CORE_CLK);
    pri <= 1'b1;
    repeat (10) @(posedge CORE_CLK);
    expect_v(1, 8'h0);
    @(posedge CORE_CLK);
    rev <= 1'b1;
    wait_for(1, 8'h1);
    expect_v(0, 8'(PRS_LOCK));
    test_done("priority");
    fail_in(1);
    wait_for(1, 8'h0);
    expect_v(0, 8'(PRS_LOCK));
    expect_v(5, 8'h2);
    fail_in(0);
    wait_for(0, 8'(PRS_HOLDOVER));
    expect_v(3, 8'h1);
    expect_v(4, 8'h1);
    expect_v(12, 8'h1);
    expect_v(8, 8'h0);
    @(posedge CORE_CLK);
    hclr <= 1'b1;
    @(posedge CORE_CLK);
    hclr <= 1'b0;
    inten <= 1'b0;
    repeat (3) @(posedge CORE_CLK);
    expect_v(4, 8'h0);
    expect_v(8, 8'h1);
    @(posedge CORE_CLK);
    inten <= 1'b1;
    test_done("failover");
    // Error in mid-count restarts validation
    run[0] <= 1'b1;
    repeat (4) @(posedge ref0);
    @(posedge CORE_CLK);
    los[0] <= 1'b1;
    @(posedge CORE_CLK);
    los[0] <= 1'b0;
    repeat (5) @(posedge ref0);
    expect_v(5, 8'h3);
    wait_for(5, 8'h2);
    wait_for(0, 8'(PRS_LOCK));
    expect_v(1, 8'h0);
    test_done("revalidate");
    @(posedge CORE_CLK);
    sel <= `PRS_REFERENCE_SELECT_FIELD_MAN0;
    run[1] <= 1'b1;
    wait_for(5, 8'h0);
    repeat (10) @(posedge CORE_CLK);
    expect_v(1, 8'h0);
    @(posedge CORE_CLK);
    sel <= `PRS_REFERENCE_SELECT_FIELD_MAN1;
    wait_for(1, 8'h1);
    fail_in(1);
    wait_for(0, 8'(PRS_HOLDOVER));
    expect_v(1, 8'h1);
    test_done("manual");
    @(posedge CORE_CLK);
    run[1] <= 1'b1;
    sel <= `PRS_REFERENCE_SELECT_FIELD_PIN;
    wait_for(0, 8'(PRS_LOCK));
    expect_v(1, 8'h0);
    expect_v(7, 8'h0);
    wait_for(5, 8'h0);
    @(posedge CORE_CLK);
    pin_drv <= 1'b1;
    wait_for(1, 8'h1);
    test_done("pin");
    @(posedge CORE_CLK);
    syn <= 1'b1;
    frc <= `PRS_FORCE_FREERUN;
    wait_for(0, 8'(PRS_FREERUN));
    expect_v(2, 8'h0);
    @(posedge CORE_CLK);
    syn <= 1'b0;
    frc <= `PRS_FORCE_NONE;
    wait_for(0, 8'(PRS_LOCK));
    test_done("synth");
    for (int i = 0; i < 8; i++) begin
      @(posedge CORE_CLK);
      bq2 <= 2'(i);
      bq3 <= 2'($urandom);
      dbl <= 1'($urandom);
      repeat (2) @(posedge CORE_CLK);
      expect_v(9, {6'h0, bq2});
      expect_v(10, {6'h0, bq3});
      expect_v(11, {7'h0, dbl});
    end
    // A failed input never drives a bypass route
    @(posedge CORE_CLK);
    bq2 <= `PRS_BYP_REF1;
    fail_in(1);
    repeat (4) @(posedge CORE_CLK);
    expect_v(9, 8'h0);
    test_done("bypass");
    complete_run();
  end
endmodule // test_pll_reference_select_fsm
